/* rtl/lrfs_params.svh */
// Constants of the linear rail fault supervisor: timing, register map, field positions.
// Assumes a single 20 MHz core clock; included by the package and the top module.
`ifndef LRFS_PARAMS_SVH
`define LRFS_PARAMS_SVH

`define LRFS_CLK_HZ          20000000
`define LRFS_STARTUP_US      16000
`define LRFS_RST_LOW_MS      8000
// Limit dwell times are not characterised here; plain defaults
`define LRFS_IO_LIM_OFF_US   1000
`define LRFS_AUX_LIM_OFF_US  1000
`define LRFS_US_TO_CYC(us)   ((us) * (`LRFS_CLK_HZ / 1000000))
`define LRFS_MS_TO_CYC(ms)   ((ms) * (`LRFS_CLK_HZ / 1000))

`define LRFS_OFS_CFG2        8'h00
`define LRFS_OFS_SUPV        8'h04
`define LRFS_OFS_CMD         8'h08
`define LRFS_OFS_STATUS      8'h0C
`define LRFS_OFS_DIAG        8'h10

`define LRFS_CFG2_LOW_LIM    0
`define LRFS_CFG2_AUX_TRK    1
`define LRFS_CFG2_XCVR_OV    2
`define LRFS_SUPV_IO_FS      0
`define LRFS_SUPV_AUX_FS     1
`define LRFS_CMD_IO_RESTART  0
`define LRFS_CMD_AUX_RESTART 1
`define LRFS_CMD_XCVR_RESTART 2
`define LRFS_CMD_END_INIT    3
`define LRFS_CMD_LOW_POWER_OFF_STATE       4

`define LRFS_DG_IO_OV        0
`define LRFS_DG_IO_UV        1
`define LRFS_DG_AUX_OV       2
`define LRFS_DG_AUX_UV       3
`define LRFS_DG_XCVR_OV      4
`define LRFS_DG_XCVR_UV      5
`define LRFS_DG_IO_LIM       6
`define LRFS_DG_AUX_LIM      7

`define LRFS_CFG2_RST        3'h0
`define LRFS_SUPV_RST        2'h3

`endif

/* rtl/lrfs_pkg.sv */
// Types shared by the linear rail fault supervisor modules.
// Assumes lrfs_params.svh is on the include path.
`include "lrfs_params.svh"

package lrfs_pkg;

  typedef enum logic [2:0] {
    ST_POR_OFF,
    ST_LOW_POWER_OFF_STATE,
    ST_START,
    ST_INIT,
    ST_RUN,
    ST_DEEP_FS
  } lrfs_seq_t;

  typedef enum logic [1:0] {
    LIM_INT,
    LIM_EXT_HIGH,
    LIM_EXT_LOW
  } lrfs_lim_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        trip;
  } lrfs_tmr_t;

  typedef struct packed {
    lrfs_seq_t   seq;
    logic [31:0] cnt;
    logic [31:0] rlow;
    logic [13:0] sync1;
    logic [13:0] sync2;
    logic        ext_pnp;
    logic        low_sel;
    logic        trk_en;
    logic        xov_en;
    logic        fs_io;
    logic        fs_aux;
    logic [7:0]  diag;
    logic        io_ov_off;
    logic        aux_ov_off;
    logic        xcvr_off;
    logic [1:0]  restart;
    logic        waitreq;
    logic [31:0] rdata;
    logic        io_en;
    logic        io_int;
    lrfs_lim_t   lim;
    logic        aux_en;
    logic        aux_trk;
    logic        xcvr_en;
    logic        xcvr_uv_en;
    logic        xcvr_ov_en;
    logic        fs_n;
    logic        rst_oe;
    logic        rst_lvl;
    logic        deep;
    logic        irq;
  } lrfs_state_t;

endpackage

/* rtl/lrfs_limit_timer.sv */
// Current-limit dwell timer: trips after a continuous limiting interval, latches.
// Assumes limiting_in is already synchronised to core_clk_in.
module lrfs_limit_timer #(
  parameter int unsigned CYCLES = 20000
) (
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  input  wire logic limiting_in,
  input  wire logic arm_in,
  input  wire logic restart_in,
  output logic      trip_out
);
  import lrfs_pkg::*;

  lrfs_tmr_t st;
  lrfs_tmr_t nx;

  always_comb begin
    nx = st;
    if (restart_in) begin
      nx.cnt  = 32'h0000_0000;
      nx.trip = 1'b0;
    end else if (st.trip) begin
      nx.trip = 1'b1;
    end else if (arm_in && limiting_in) begin
      if (st.cnt >= 32'(CYCLES - 1)) begin
        nx.trip = 1'b1;
      end else begin
        nx.cnt = st.cnt + 32'h0000_0001;
      end
    end else begin
      // Dwell must be continuous; any gap starts it over
      nx.cnt = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign trip_out = st.trip;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_trip_at_count: assert property (arm_in && limiting_in && !restart_in && !st.trip
      && st.cnt == 32'(CYCLES - 1) |=> st.trip)
    else $error("dwell timer did not trip at its count");
  a_trip_latched: assert property (st.trip && !restart_in |=> st.trip)
    else $error("limit shutdown released without restart");
  a_restart_clears: assert property (restart_in |=> !st.trip && st.cnt == 32'h0000_0000)
    else $error("restart did not clear dwell timer");
endmodule

/* rtl/lrfs_top.sv */
// Linear rail fault supervisor: start-up sequencer, reset-low watchdog and
// fault handling for the I/O-reference, auxiliary and transceiver supply rails.
// Assumes analog comparators arrive asynchronously on pins and software uses Avalon-MM.
// Operation
// - At start-up sense an external pass transistor; if present, disable the internal one.
// - Default I/O-rail limit threshold follows the start-up transistor detection.
// - With internal transistor, limiting only clamps; the I/O rail stays enabled.
// - With external transistor, I/O rail turns off after its limit dwell, until restart.
// - Low-threshold setting in regulator_init_config2 applies only with external transistor.
// - I/O rail: overvoltage turns off, undervoltage not; both flag; fail-safe per config.
// - Aux rail: overvoltage turns off, undervoltage not; both flag; fail-safe per config.
// - aux_tracking_enable is writable only in the initialization phase, then locked.
// - Aux rail turns off after its limit dwell and restarts by command or on a new start-up.
// - After reset transceiver rail and its undervoltage detector on, overvoltage detector off.
// - Transceiver overvoltage detector is enabled only by a write during initialization.
// - Enabled transceiver overvoltage turns the rail off and raises a flag.
// - Transceiver undervoltage detector is disabled while that rail is off.
// - Transceiver rail faults never affect reset_out_n or failsafe_out_n.
// - Undervoltage lockout applies from power-on only; low-power-off restarts on low threshold.
// - Start-up brings rails up and releases reset_out_n after 16 ms.
// - reset_out_n low for 8.0 s sends the device to deep fail-safe.
`include "lrfs_params.svh"
module lrfs_top #(
  parameter int unsigned STARTUP_CYCLES = `LRFS_US_TO_CYC(`LRFS_STARTUP_US),
  parameter int unsigned RST_LOW_CYCLES = `LRFS_MS_TO_CYC(`LRFS_RST_LOW_MS),
  parameter int unsigned IO_LIM_CYCLES  = `LRFS_US_TO_CYC(`LRFS_IO_LIM_OFF_US),
  parameter int unsigned AUX_LIM_CYCLES = `LRFS_US_TO_CYC(`LRFS_AUX_LIM_OFF_US)
) (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        supply_por_ok_in,
  input  wire logic        supply_low_ok_in,
  input  wire logic        low_power_off_state_wake_in,
  input  wire logic        ext_pnp_sense_in,
  input  wire logic        analog_builtin_self_test_fault_in,
  input  wire logic        io_ov_in,
  input  wire logic        io_uv_in,
  input  wire logic        io_ilim_in,
  input  wire logic        aux_ov_in,
  input  wire logic        aux_uv_in,
  input  wire logic        aux_ilim_in,
  input  wire logic        xcvr_ov_in,
  input  wire logic        xcvr_uv_in,
  input  wire logic        reset_out_n_in,
  output logic             reset_out_n_out,
  output logic             reset_out_n_oe_out,
  output logic             failsafe_out_n_out,
  output logic             deep_failsafe_out,
  output logic             io_rail_en_out,
  output logic             io_int_pass_en_out,
  output lrfs_pkg::lrfs_lim_t io_limit_sel_out,
  output logic             aux_rail_en_out,
  output logic             aux_track_out,
  output logic             xcvr_rail_en_out,
  output logic             xcvr_uv_det_en_out,
  output logic             xcvr_ov_det_en_out,
  output logic             irq_out
);
  import lrfs_pkg::*;

  lrfs_state_t st;
  lrfs_state_t nx;
  logic        s_por, s_low, s_wake, s_pnp, s_analog_builtin_self_test;
  logic        s_io_ov, s_io_uv, s_io_ilim, s_aux_ov, s_aux_uv, s_aux_ilim;
  logic        s_xcvr_ov, s_xcvr_uv, s_rstn;
  logic        io_trip, aux_trip;
  logic        fs_trig;
  logic [7:0]  diag_set;
  logic [7:0]  diag_clr;
  logic [4:0]  cmd;
  logic [7:0]  wd;
  logic        wr_ok;

  function automatic logic rails_up(input lrfs_seq_t s);
    return (s == ST_START) || (s == ST_INIT) || (s == ST_RUN);
  endfunction

  function automatic logic sw_phase(input lrfs_seq_t s);
    return (s == ST_INIT) || (s == ST_RUN);
  endfunction

  assign {s_por, s_low, s_wake, s_pnp, s_analog_builtin_self_test, s_io_ov, s_io_uv, s_io_ilim,
          s_aux_ov, s_aux_uv, s_aux_ilim, s_xcvr_ov, s_xcvr_uv, s_rstn} = st.sync2;

  // I/O rail dwell only counts with the external transistor fitted
  lrfs_limit_timer #(.CYCLES(IO_LIM_CYCLES)) u_io_tmr (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .limiting_in (s_io_ilim),
    .arm_in      (rails_up(st.seq) && !st.io_ov_off && st.ext_pnp),
    .restart_in  (st.restart[0] || !rails_up(st.seq)),
    .trip_out    (io_trip)
  );

  lrfs_limit_timer #(.CYCLES(AUX_LIM_CYCLES)) u_aux_tmr (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .limiting_in (s_aux_ilim),
    .arm_in      (rails_up(st.seq) && !st.aux_ov_off),
    .restart_in  (st.restart[1] || !rails_up(st.seq)),
    .trip_out    (aux_trip)
  );

  always_comb begin
    nx = st;
    nx.sync1 = {supply_por_ok_in, supply_low_ok_in, low_power_off_state_wake_in, ext_pnp_sense_in,
                analog_builtin_self_test_fault_in, io_ov_in, io_uv_in, io_ilim_in, aux_ov_in, aux_uv_in,
                aux_ilim_in, xcvr_ov_in, xcvr_uv_in, reset_out_n_in};
    nx.sync2   = st.sync1;
    nx.restart = 2'h0;
    nx.waitreq = 1'b1;
    nx.rdata   = 32'h0000_0000;
    nx.rst_lvl = 1'b0;
    diag_set   = 8'h00;
    diag_clr   = 8'h00;
    cmd        = 5'h00;
    wd         = avs_writedata_in[7:0];
    // Answer one cycle after the request; the write lands on the waitrequest-low edge
    wr_ok      = avs_write_in && !st.waitreq && avs_byteenable_in[0];
    if ((avs_read_in || avs_write_in) && st.waitreq) begin
      nx.waitreq = 1'b0;
      if (avs_read_in) begin
        case (avs_address_in)
          `LRFS_OFS_CFG2: begin
            nx.rdata[`LRFS_CFG2_LOW_LIM] = st.low_sel;
            nx.rdata[`LRFS_CFG2_AUX_TRK] = st.trk_en;
            nx.rdata[`LRFS_CFG2_XCVR_OV] = st.xov_en;
          end
          `LRFS_OFS_SUPV: begin
            nx.rdata[`LRFS_SUPV_IO_FS]  = st.fs_io;
            nx.rdata[`LRFS_SUPV_AUX_FS] = st.fs_aux;
          end
          `LRFS_OFS_STATUS: begin
            nx.rdata[10:0] = {st.seq, 1'b0, aux_trip, io_trip, st.fs_n, st.xcvr_en,
                              st.aux_en, st.io_en, st.ext_pnp};
          end
          `LRFS_OFS_DIAG: nx.rdata[7:0] = st.diag;
          default: nx.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_ok) begin
      case (avs_address_in)
        `LRFS_OFS_CFG2: begin
          nx.low_sel = wd[`LRFS_CFG2_LOW_LIM];
          if (st.seq == ST_INIT) begin
            nx.trk_en = wd[`LRFS_CFG2_AUX_TRK];
            nx.xov_en = wd[`LRFS_CFG2_XCVR_OV];
          end
        end
        `LRFS_OFS_SUPV: begin
          nx.fs_io  = wd[`LRFS_SUPV_IO_FS];
          nx.fs_aux = wd[`LRFS_SUPV_AUX_FS];
        end
        `LRFS_OFS_CMD:  cmd = wd[4:0];
        `LRFS_OFS_DIAG: diag_clr = wd;
        default: ;
      endcase
    end

    if (sw_phase(st.seq)) begin
      if (s_io_ov) begin
        nx.io_ov_off = 1'b1;
        diag_set[`LRFS_DG_IO_OV] = 1'b1;
      end
      if (s_io_uv && st.io_en) diag_set[`LRFS_DG_IO_UV] = 1'b1;
      if (s_aux_ov) begin
        nx.aux_ov_off = 1'b1;
        diag_set[`LRFS_DG_AUX_OV] = 1'b1;
      end
      if (s_aux_uv && st.aux_en) diag_set[`LRFS_DG_AUX_UV] = 1'b1;
      if (st.xov_en && s_xcvr_ov) begin
        nx.xcvr_off = 1'b1;
        diag_set[`LRFS_DG_XCVR_OV] = 1'b1;
      end
      if (s_xcvr_uv && st.xcvr_uv_en) diag_set[`LRFS_DG_XCVR_UV] = 1'b1;
    end
    diag_set[`LRFS_DG_IO_LIM]  = io_trip;
    diag_set[`LRFS_DG_AUX_LIM] = aux_trip;
    // A flag raised in the same cycle as its clear survives
    nx.diag = (st.diag & ~diag_clr) | diag_set;
    if (sw_phase(st.seq)) begin
      if (cmd[`LRFS_CMD_IO_RESTART]) begin
        nx.io_ov_off  = s_io_ov; // A live overvoltage outlasts the restart
        nx.restart[0] = 1'b1;
      end
      if (cmd[`LRFS_CMD_AUX_RESTART]) begin
        nx.aux_ov_off = s_aux_ov;
        nx.restart[1] = 1'b1;
      end
      if (cmd[`LRFS_CMD_XCVR_RESTART]) nx.xcvr_off = st.xov_en && s_xcvr_ov;
      if (cmd[`LRFS_CMD_END_INIT] && st.seq == ST_INIT) nx.seq = ST_RUN;
      if (cmd[`LRFS_CMD_LOW_POWER_OFF_STATE]) nx.seq = ST_LOW_POWER_OFF_STATE;
    end

    // Transceiver rail faults are deliberately absent here
    fs_trig = sw_phase(st.seq) && ((st.fs_io && (s_io_ov || s_io_uv)) ||
                                   (st.fs_aux && (s_aux_ov || s_aux_uv)));
    if (fs_trig) nx.fs_n = 1'b0;

    case (st.seq)
      ST_POR_OFF: begin
        nx.cnt = 32'h0000_0000;
        if (s_por) begin
          nx.seq     = ST_START;
          nx.ext_pnp = s_pnp;
        end
      end
      ST_LOW_POWER_OFF_STATE: begin
        nx.cnt = 32'h0000_0000;
        if (s_wake && s_low) begin
          nx.seq     = ST_START;
          nx.ext_pnp = s_pnp;
        end
      end
      ST_START: begin
        // A self-test fault holds start-up; the reset-low watchdog ends it
        if (st.cnt >= 32'(STARTUP_CYCLES - 1)) begin
          if (!s_analog_builtin_self_test) nx.seq = ST_INIT;
        end else begin
          nx.cnt = st.cnt + 32'h0000_0001;
        end
      end
      ST_INIT, ST_RUN: ;
      ST_DEEP_FS: begin
        if (!s_por) nx.seq = ST_POR_OFF;
      end
      default: nx.seq = ST_POR_OFF;
    endcase

    // The host may hold reset low too; the sensed pin level is what counts
    if (rails_up(st.seq) && !s_rstn) begin
      if (st.rlow >= 32'(RST_LOW_CYCLES - 1)) begin
        nx.seq  = ST_DEEP_FS;
        nx.rlow = 32'h0000_0000;
      end else begin
        nx.rlow = st.rlow + 32'h0000_0001;
      end
    end else begin
      nx.rlow = 32'h0000_0000;
    end

    if (rails_up(st.seq) && !s_low) nx.seq = ST_POR_OFF;
    if (nx.seq == ST_POR_OFF) begin
      nx.fs_n       = 1'b1;
      nx.io_ov_off  = 1'b0;
      nx.aux_ov_off = 1'b0;
      nx.xcvr_off   = 1'b0;
    end
    if (nx.seq == ST_DEEP_FS) nx.fs_n = 1'b0;

    nx.io_en      = rails_up(nx.seq) && !nx.io_ov_off && !io_trip;
    nx.io_int     = nx.io_en && !nx.ext_pnp;
    nx.lim        = !nx.ext_pnp ? LIM_INT :
                    (nx.low_sel ? LIM_EXT_LOW : LIM_EXT_HIGH);
    nx.aux_en     = rails_up(nx.seq) && !nx.aux_ov_off && !aux_trip;
    nx.aux_trk    = nx.trk_en;
    nx.xcvr_en    = rails_up(nx.seq) && !nx.xcvr_off;
    nx.xcvr_uv_en = nx.xcvr_en;
    nx.xcvr_ov_en = nx.xcvr_en && nx.xov_en;
    nx.rst_oe     = !sw_phase(nx.seq);
    nx.deep       = nx.seq == ST_DEEP_FS;
    nx.irq        = |nx.diag;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st         <= '0;
      st.low_sel <= 1'(`LRFS_CFG2_RST >> `LRFS_CFG2_LOW_LIM);
      st.fs_io   <= 1'b1;
      st.fs_aux  <= 1'b1;
      st.waitreq <= 1'b1;
      st.fs_n    <= 1'b1;
      st.rst_oe  <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign avs_readdata_out    = st.rdata;
  assign avs_waitrequest_out = st.waitreq;
  assign reset_out_n_out     = st.rst_lvl;
  assign reset_out_n_oe_out  = st.rst_oe;
  assign failsafe_out_n_out  = st.fs_n;
  assign deep_failsafe_out   = st.deep;
  assign io_rail_en_out      = st.io_en;
  assign io_int_pass_en_out  = st.io_int;
  assign io_limit_sel_out    = st.lim;
  assign aux_rail_en_out     = st.aux_en;
  assign aux_track_out       = st.aux_trk;
  assign xcvr_rail_en_out    = st.xcvr_en;
  assign xcvr_uv_det_en_out  = st.xcvr_uv_en;
  assign xcvr_ov_det_en_out  = st.xcvr_ov_en;
  assign irq_out             = st.irq;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_pnp_int_off: assert property (io_int_pass_en_out |-> !st.ext_pnp)
    else $error("internal pass on with external transistor");
  a_limit_default: assert property ((io_limit_sel_out == LIM_INT) == !st.ext_pnp)
    else $error("limit threshold does not follow detection");
  a_int_lim_stays: assert property (!st.ext_pnp && rails_up(st.seq) && !st.io_ov_off
      && s_io_ilim |-> io_rail_en_out)
    else $error("internal-transistor rail shut by limiting");
  a_io_trip_off: assert property (io_trip |=> !io_rail_en_out)
    else $error("I/O rail on after limit trip");
  a_low_lim_ext: assert property (io_limit_sel_out == LIM_EXT_LOW |-> st.ext_pnp && st.low_sel)
    else $error("low threshold without external transistor");
  a_io_ov_off: assert property (sw_phase(st.seq) && s_io_ov |=> !io_rail_en_out)
    else $error("I/O rail not off after overvoltage");
  a_aux_ov_off: assert property (sw_phase(st.seq) && s_aux_ov |=> !aux_rail_en_out)
    else $error("aux rail not off after overvoltage");
  a_trk_locked: assert property (st.seq != ST_INIT |=> $stable(st.trk_en))
    else $error("tracking choice changed outside init");
  a_ov_en_locked: assert property (st.seq != ST_INIT |=> $stable(st.xov_en))
    else $error("overvoltage enable changed outside init");
  a_xcvr_ov_off: assert property (sw_phase(st.seq) && st.xov_en && s_xcvr_ov && s_low
      |=> !xcvr_rail_en_out && st.diag[`LRFS_DG_XCVR_OV])
    else $error("transceiver rail not off after overvoltage");
  a_xcvr_uv_gate: assert property (!st.xcvr_uv_en |-> !diag_set[`LRFS_DG_XCVR_UV])
    else $error("undervoltage detector active with rail off");
  a_fs_cause: assert property ($fell(st.fs_n) |-> $past(fs_trig) || st.seq == ST_DEEP_FS)
    else $error("fail-safe asserted without a safety cause");
  a_uvlo_hold: assert property (st.seq == ST_POR_OFF && !s_por |=> st.seq == ST_POR_OFF)
    else $error("left power-on lockout below threshold");
  a_reset_release: assert property (st.seq == ST_START && !s_analog_builtin_self_test && s_low
      && st.cnt == 32'(STARTUP_CYCLES - 1) |=> st.seq == ST_INIT && !reset_out_n_oe_out)
    else $error("reset not released at end of start-up");
  a_deep_entry: assert property (rails_up(st.seq) && !s_rstn && s_low
      && st.rlow == 32'(RST_LOW_CYCLES - 1) |=> st.seq == ST_DEEP_FS && deep_failsafe_out)
    else $error("deep fail-safe not entered after reset-low time");
endmodule

/* verification/lrfs_host_model.sv */
// Host side of the reset wire: open-drain line with pull-up, shared with the supervisor.
// Assumes the host asks to hold reset only after the supervisor has released it once.
module lrfs_host_model (
  input  wire logic core_clk_in,
  input  wire logic dut_oe_in,
  input  wire logic hold_req_in,
  output logic      reset_wire_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic started_reg = 1'h0;
  logic hold_reg    = 1'h0;
  always_ff @(posedge core_clk_in) begin
    if (!dut_oe_in) begin
      started_reg <= 1'h1;
    end
    // Holding before the first release would hide the start-up timing
    hold_reg <= hold_req_in && (started_reg || !dut_oe_in);
  end
  // Pull-up: released wire reads high
  assign reset_wire_out = !(dut_oe_in || hold_reg);
endmodule

/* verification/tb_top.sv */
// Self-checking bench of the rail fault supervisor with short counts.
// Assumes lrfs_pkg is compiled first and the host model drives the reset wire.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lrfs_pkg::*;
  localparam int unsigned SU  = 20;
  localparam int unsigned RL  = 200;
  localparam int unsigned LIM = 8;
  logic        core_clk_in = 1'h0, rstn_in = 1'h0, avs_read_in = 1'h0, avs_write_in = 1'h0;
  logic [7:0]  avs_address_in    = 8'h00;
  logic [31:0] avs_writedata_in  = 32'h0000_0000;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic        supply_por_ok_in = 1'h1, supply_low_ok_in = 1'h1, low_power_off_state_wake_in = 1'h0;
  logic        ext_pnp_sense_in = 1'h1, analog_builtin_self_test_fault_in = 1'h0, hold_req = 1'h0;
  logic        io_ov_in = 1'h0, io_uv_in = 1'h0, io_ilim_in = 1'h0, aux_ov_in = 1'h0;
  logic        aux_uv_in = 1'h0, aux_ilim_in = 1'h0, xcvr_ov_in = 1'h0, xcvr_uv_in = 1'h0;
  logic [31:0] avs_readdata_out, q;
  logic        avs_waitrequest_out, reset_out_n_in, reset_out_n_out, reset_out_n_oe_out;
  logic        failsafe_out_n_out, deep_failsafe_out, io_rail_en_out, io_int_pass_en_out;
  logic        aux_rail_en_out, aux_track_out, xcvr_rail_en_out, xcvr_uv_det_en_out;
  logic        xcvr_ov_det_en_out, irq_out;
  lrfs_lim_t   io_limit_sel_out;
  int          error_cnt = 0, samples_checked = 0, n;

  lrfs_top #(.STARTUP_CYCLES(SU), .RST_LOW_CYCLES(RL), .IO_LIM_CYCLES(LIM),
    .AUX_LIM_CYCLES(LIM)) i_dut (.core_clk_in, .rstn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .supply_por_ok_in, .supply_low_ok_in, .low_power_off_state_wake_in,
    .ext_pnp_sense_in, .analog_builtin_self_test_fault_in, .io_ov_in, .io_uv_in, .io_ilim_in, .aux_ov_in,
    .aux_uv_in, .aux_ilim_in, .xcvr_ov_in, .xcvr_uv_in, .reset_out_n_in, .reset_out_n_out,
    .reset_out_n_oe_out, .failsafe_out_n_out, .deep_failsafe_out, .io_rail_en_out,
    .io_int_pass_en_out, .io_limit_sel_out, .aux_rail_en_out, .aux_track_out,
    .xcvr_rail_en_out, .xcvr_uv_det_en_out, .xcvr_ov_det_en_out, .irq_out);
  lrfs_host_model i_host (.core_clk_in(core_clk_in), .dut_oe_in(reset_out_n_oe_out),
    .hold_req_in(hold_req), .reset_wire_out(reset_out_n_in));

  always #25 core_clk_in = ~core_clk_in;

  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'h0 && k < 20);
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in  <= 1'h0;
    if (k >= 20) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return reset_out_n_oe_out;
      1: return io_rail_en_out;
      2: return aux_rail_en_out;
      default: return deep_failsafe_out;
    endcase
  endfunction

  task automatic wait_sig(input int s, input logic v);
    n = 0;
    while (sig(s) !== v && n < 2000) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic startup(input logic ext);
    wait_sig(0, 1'h0);
    chk(n >= SU && n <= SU + 8, 1'h1);
    chk(io_int_pass_en_out, !ext);
    chk(io_limit_sel_out, ext ? LIM_EXT_HIGH : LIM_INT);
    chk({xcvr_rail_en_out, xcvr_uv_det_en_out, xcvr_ov_det_en_out}, 3'h6);
  endtask

  task automatic lim_trip(input int s, input logic [31:0] cmd);
    if (s == 1) io_ilim_in <= 1'h1;
    else aux_ilim_in <= 1'h1;
    wait_sig(s, 1'h0);
    chk(n >= LIM && n <= LIM + 6, 1'h1);
    io_ilim_in  <= 1'h0;
    aux_ilim_in <= 1'h0;
    bus(1'h1, 8'h08, cmd);
    wait_sig(s, 1'h1);
    chk(n <= 4, 1'h1);
  endtask

  task automatic rail_faults();
    xcvr_ov_in <= 1'h1;
    repeat (6) @(posedge core_clk_in);
    chk({xcvr_rail_en_out, xcvr_uv_det_en_out, irq_out}, 3'h1);
    chk({reset_out_n_in, failsafe_out_n_out}, 2'h3);
    xcvr_ov_in <= 1'h0;
    xcvr_uv_in <= 1'h1;
    // Let the undervoltage pass the synchroniser before the flags are read
    repeat (4) @(posedge core_clk_in);
    bus(1'h0, 8'h10, 32'h0000_0000);
    chk(q[5:4], 2'h1);
    xcvr_uv_in <= 1'h0;
    bus(1'h1, 8'h10, 32'h0000_00ff);
    bus(1'h0, 8'h10, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(irq_out, 1'h0);
    io_ov_in  <= 1'h1;
    aux_uv_in <= 1'h1;
    repeat (6) @(posedge core_clk_in);
    chk({io_rail_en_out, failsafe_out_n_out, aux_rail_en_out, irq_out}, 4'h3);
    bus(1'h0, 8'h10, 32'h0000_0000);
    chk(q[3:0], 4'h9);
    io_ov_in  <= 1'h0;
    aux_uv_in <= 1'h0;
    aux_ov_in <= 1'h1;
    repeat (6) @(posedge core_clk_in);
    chk(aux_rail_en_out, 1'h0);
    aux_ov_in <= 1'h0;
  endtask

  initial begin
    repeat (5) @(posedge core_clk_in);
    rstn_in <= 1'h1;
    startup(1'h1);
    bus(1'h1, 8'h00, 32'h0000_0007);
    repeat (3) @(posedge core_clk_in);
    chk({io_limit_sel_out, aux_track_out, xcvr_ov_det_en_out}, {LIM_EXT_LOW, 2'h3});
    bus(1'h1, 8'h08, 32'h0000_0008);
    bus(1'h1, 8'h00, 32'h0000_0000);
    repeat (3) @(posedge core_clk_in);
    chk({io_limit_sel_out, aux_track_out, xcvr_ov_det_en_out}, {LIM_EXT_HIGH, 2'h3});
    lim_trip(1, 32'h0000_0001);
    lim_trip(1, 32'h0000_0001);
    lim_trip(2, 32'h0000_0002);
    rail_faults();
    bus(1'h1, 8'h08, 32'h0000_0010);
    wait_sig(0, 1'h1);
    supply_por_ok_in <= 1'h0;
    low_power_off_state_wake_in    <= 1'h1;
    wait_sig(0, 1'h0);
    chk(n <= SU + 12, 1'h1);
    low_power_off_state_wake_in <= 1'h0;
    hold_req      <= 1'h1;
    wait_sig(3, 1'h1);
    chk({n >= RL && n <= RL + 8, failsafe_out_n_out}, 2'h2);
    hold_req <= 1'h0;
    repeat (40) @(posedge core_clk_in);
    chk(reset_out_n_oe_out, 1'h1);
    rstn_in          <= 1'h0;
    ext_pnp_sense_in <= 1'h0;
    supply_por_ok_in <= 1'h1;
    repeat (5) @(posedge core_clk_in);
    rstn_in <= 1'h1;
    startup(1'h0);
    io_ilim_in <= 1'h1;
    repeat (30) @(posedge core_clk_in);
    chk({io_rail_en_out, io_int_pass_en_out}, 2'h3);
    io_ilim_in <= 1'h0;
    bus(1'h1, 8'h08, 32'h0000_0008);
    bus(1'h1, 8'h00, 32'h0000_0004);
    repeat (3) @(posedge core_clk_in);
    chk(xcvr_ov_det_en_out, 1'h0);
    // A self-test fault holds start-up until the reset-low watchdog ends it
    analog_builtin_self_test_fault_in <= 1'h1;
    rstn_in        <= 1'h0;
    repeat (5) @(posedge core_clk_in);
    rstn_in <= 1'h1;
    wait_sig(3, 1'h1);
    chk({n >= RL && n <= RL + 8, reset_out_n_oe_out, failsafe_out_n_out}, 3'h6);
    end_of_test();
  end
endmodule
